// [adc_digital_port.sv]
// Digital side of a 10-bit pipelined converter: sample capture, latency
// pipeline, saturation, output format, shared result pins and control
// registers written over those pins or over classic Wishbone.
// Assumes REF_CLK is the sample clock and all inputs are synchronous.
//
// Behaviour
// - capture input sample every rising clock edge while awake
// - result appears fourth edge after capture
// - output enable high releases the result pins
// - write strobe latches word from shared pins
// - control registers set format, gain, sleep, clamp
// - range flag high with out-of-range sample
// - saturate under to 0, over to 1023
// - clamp level from external pin or DAC
// - control bit 3 selects power-down
// - control bit 5 selects twos complement
// - control bit 6 disables the clamp
// - range flag released while output enable high
//
// The register offsets and the Wishbone slave port were decided locally.
`timescale 1ns/10ps
`include "adc_port_params.svh"
module adc_digital_port
(
   // Clock and reset
   input  wire logic        REF_CLK,
   input  wire logic        SYS_RST,
   // Converter core sample, signed value with range state
   input  wire logic [10:0] SAMPLE_VALUE,
   input  wire logic        SAMPLE_UNDER,
   input  wire logic        SAMPLE_OVER,
   // Shared result and configuration pins
   input  wire logic [9:0]  RESULT_BUS_IN,
   output logic      [9:0]  RESULT_BUS_OUT,
   output logic             RESULT_BUS_OE,
   output logic             RANGE_EXCEEDED_FLAG,
   output logic             RANGE_FLAG_OE,
   input  wire logic        OUTPUT_ENABLE_N,
   input  wire logic        WRITE_STROBE,
   // Analog control outputs
   output logic             SLEEP_OUT,
   output logic             CLAMP_ENABLE,
   output logic             CLAMP_FROM_DAC,
   output logic      [9:0]  CLAMP_DAC_CODE,
   output logic      [2:0]  GAIN_CODE,
   // Wishbone slave
   input  wire logic        CYC_I,
   input  wire logic        STB_I,
   input  wire logic        WE_I,
   input  wire logic [3:0]  ADR_I,
   input  wire logic [3:0]  SEL_I,
   input  wire logic [31:0] DAT_I,
   output logic      [31:0] DAT_O,
   output logic             ACK_O
);
   // Control state written from the pins or over the bus.
   logic [7:0]          control_reg;
   logic [7:0]          control_next;
   logic [9:0]          clamp_reg;
   logic [9:0]          clamp_next;
   logic [2:0]          gain_reg;
   logic [2:0]          gain_next;
   logic                strobe_reg;
   logic                strobe_next;
   logic [9:0]          latch_reg;
   logic [9:0]          latch_next;

   // Sample path from capture to the pins.
   adc_port_pkg::code_t  cap_code_reg;
   adc_port_pkg::code_t  cap_code_next;
   adc_port_pkg::range_t cap_rng_reg;
   adc_port_pkg::range_t cap_rng_next;
   adc_port_pkg::code_t  pipe_code;
   adc_port_pkg::range_t pipe_rng;
   logic [9:0]          out_code_reg;
   logic [9:0]          out_code_next;
   logic                out_flag_reg;
   logic                out_flag_next;

   // Bus answer and the two request decodes.
   logic                ack_reg;
   logic                ack_next;
   logic [31:0]         dat_reg;
   logic [31:0]         dat_next;
   logic                cfg_fire;
   logic                wb_req;

   // Saturating conversion of the signed core value to an unsigned code.
   // Adding 512 maps -512..511 onto 0..1023; bit 10 set means out of range.
   function automatic adc_port_pkg::code_t saturate
   (
      input logic [10:0] value,
      input logic        under,
      input logic        over
   );
      logic [10:0] biased;
      biased = value + 11'h200;
      if (under || value[10] && biased[10])
         saturate = `CODE_MIN;
      else if (over || biased[10])
         saturate = `CODE_MAX;
      else
         saturate = biased[9:0];
   endfunction

   // Range state of a sample, used only by the range flag; saturate decodes the same cases itself.
   function automatic adc_port_pkg::range_t classify
   (
      input logic [10:0] value,
      input logic        under,
      input logic        over
   );
      logic [10:0] biased;
      biased = value + 11'h200;
      if (under || value[10] && biased[10])
         classify = adc_port_pkg::RANGE_UNDER;
      else if (over || biased[10])
         classify = adc_port_pkg::RANGE_OVER;
      else
         classify = adc_port_pkg::RANGE_OK;
   endfunction

   // A pin write takes effect on the falling edge of the strobe.
   // It needs the outputs still off, so a bus clash never writes a register.
   assign cfg_fire = strobe_reg && !WRITE_STROBE && OUTPUT_ENABLE_N;
   // A request is answered once; the ack cycle never starts a second one.
   assign wb_req   = CYC_I && STB_I && !ack_reg;

   always_comb
   begin
      strobe_next  = WRITE_STROBE;
      latch_next   = latch_reg;
      control_next = control_reg;
      clamp_next   = clamp_reg;
      gain_next    = gain_reg;
      if (WRITE_STROBE && OUTPUT_ENABLE_N)
         latch_next = RESULT_BUS_IN;
      if (cfg_fire)
      begin
         case (latch_reg[`ADDR_LSB +: `ADDR_W])
            `IDX_CONTROL: control_next = latch_reg[7:0];
            `IDX_GAIN:    gain_next    = latch_reg[`GAIN_W-1:0];
            `IDX_CLAMP:   clamp_next   = {2'h0, latch_reg[7:0]};
            // Index 3 also loads the clamp; the pins carry its low byte.
            default:      clamp_next   = {2'h0, latch_reg[7:0]};
         endcase
      end
      // Bus writes come last, so they win over a pin write in one cycle.
      if (wb_req && WE_I)
      begin
         case (ADR_I)
            `WB_CONTROL:
            begin
               if (SEL_I[0])
                  control_next = DAT_I[7:0];
            end
            `WB_CLAMP:
            begin
               if (SEL_I[0])
                  clamp_next[7:0] = DAT_I[7:0];
               if (SEL_I[1])
                  clamp_next[9:8] = DAT_I[9:8];
            end
            `WB_GAIN:
            begin
               if (SEL_I[0])
                  gain_next = DAT_I[`GAIN_W-1:0];
            end
            default:
            begin
               control_next = control_next;
            end
         endcase
      end
   end

   // Control state registers.
   always_ff @(posedge REF_CLK)
   begin
      if (SYS_RST)
      begin
         strobe_reg  <= 1'b0;
         latch_reg   <= 10'h000;
         control_reg <= `CONTROL_RST;
         clamp_reg   <= `CLAMP_RST;
         gain_reg    <= `GAIN_RST;
      end
      else
      begin
         strobe_reg  <= strobe_next;
         latch_reg   <= latch_next;
         control_reg <= control_next;
         clamp_reg   <= clamp_next;
         gain_reg    <= gain_next;
      end
   end

   always_comb
   begin
      cap_code_next = saturate(SAMPLE_VALUE, SAMPLE_UNDER, SAMPLE_OVER);
      cap_rng_next  = classify(SAMPLE_VALUE, SAMPLE_UNDER, SAMPLE_OVER);
      // Idle codes keep stale samples from leaving after wake-up.
      // sleep holds converter idle
      if (control_reg[`SLEEP_BIT])
      begin
         cap_code_next = `CODE_MIN;
         cap_rng_next  = adc_port_pkg::RANGE_OK;
      end
      // The format applies at the output, so a change acts at once.
      // twos complement flips msb
      if (control_reg[`SIGNED_BIT])
         out_code_next = pipe_code ^ `MSB_FLIP;
      else
         out_code_next = pipe_code;
      out_flag_next = (pipe_rng != adc_port_pkg::RANGE_OK);
   end

   always_ff @(posedge REF_CLK)
   begin
      if (SYS_RST)
      begin
         cap_code_reg <= `CODE_MIN;
         cap_rng_reg  <= adc_port_pkg::RANGE_OK;
         out_code_reg <= `CODE_MIN;
         out_flag_reg <= 1'b0;
      end
      else
      begin
         cap_code_reg <= cap_code_next;
         cap_rng_reg  <= cap_rng_next;
         out_code_reg <= out_code_next;
         out_flag_reg <= out_flag_next;
      end
   end

   // Capture register, three pipe stages and the output register
   // together give a latency of five edges.
   // result four edges after capture
   adc_pipe u_pipe
   (
      .clk       (REF_CLK),
      .rst       (SYS_RST),
      .in_code   (cap_code_reg),
      .in_range  (cap_rng_reg),
      .out_code  (pipe_code),
      .out_range (pipe_rng)
   );

   // Results and the range flag come straight from flip-flops.
   // saturated codes leave the pins
   assign RESULT_BUS_OUT      = out_code_reg;
   assign RANGE_EXCEEDED_FLAG = out_flag_reg;
   assign RESULT_BUS_OE       = !OUTPUT_ENABLE_N;
   assign RANGE_FLAG_OE       = !OUTPUT_ENABLE_N;

   assign SLEEP_OUT      = control_reg[`SLEEP_BIT];
   assign GAIN_CODE      = gain_reg;
   assign CLAMP_ENABLE   = !control_reg[`CLAMP_OFF_BIT];
   assign CLAMP_FROM_DAC = control_reg[`CLAMP_SRC_BIT];
   assign CLAMP_DAC_CODE = clamp_reg;

   // Read data is registered with the ack and unmapped reads give zero.
   always_comb
   begin
      ack_next = wb_req;
      dat_next = dat_reg;
      if (wb_req && !WE_I)
      begin
         case (ADR_I)
            `WB_SAMPLE:  dat_next = {21'h0, out_flag_reg, out_code_reg};
            `WB_CONTROL: dat_next = {24'h0, control_reg};
            `WB_CLAMP:   dat_next = {22'h0, clamp_reg};
            `WB_GAIN:    dat_next = {29'h0, gain_reg};
            default:     dat_next = 32'h0;
         endcase
      end
   end

   always_ff @(posedge REF_CLK)
   begin
      if (SYS_RST)
      begin
         ack_reg <= 1'b0;
         dat_reg <= 32'h0;
      end
      else
      begin
         ack_reg <= ack_next;
         dat_reg <= dat_next;
      end
   end

   assign ACK_O = ack_reg;
   assign DAT_O = dat_reg;
endmodule

// [adc_host_model.sv]
// Host side of the shared pins: output enable, write strobe, config word.
// Assumes the bench calls pin_write between its own pin checks.
`timescale 1ns/10ps
module adc_host_model
(
   // Clock
   input  wire logic       clk,
   // Device pin drivers
   input  wire logic [9:0] dev_out,
   input  wire logic       dev_oe,
   // Pin levels and host controls
   output logic      [9:0] pins,
   output logic            oe_n,
   output logic            strobe
);
   logic [9:0] word;
   logic       drive;
   logic [9:0] last;
   initial
   begin
      oe_n = 1'b0; strobe = 1'b0; drive = 1'b0; word = 10'h000; last = 10'h000;
   end
   // Undriven pins show a pattern that changes every cycle.
   always_comb
      pins = dev_oe ? dev_out : (drive ? word : ~last);
   always @(posedge clk)
      last <= pins;
   task automatic pin_write(input logic [9:0] w, input logic en_n);
      @(posedge clk); oe_n <= en_n;
      @(posedge clk); drive <= 1'b1; word <= w; strobe <= 1'b1;
      @(posedge clk); strobe <= 1'b0;
      @(posedge clk); drive <= 1'b0;
      @(posedge clk); oe_n <= 1'b0;
   endtask
endmodule

// [adc_pipe.sv]
// Fixed-depth pipeline carrying codes and range state to the output.
// Assumes one clock, a synchronous active-high reset.
`timescale 1ns/10ps
`include "adc_port_params.svh"
module adc_pipe
(
   // Clock and reset
   input  wire logic                 clk,
   input  wire logic                 rst,
   // Stage input
   input  wire adc_port_pkg::code_t  in_code,
   input  wire adc_port_pkg::range_t in_range,
   // Stage output
   output adc_port_pkg::code_t       out_code,
   output adc_port_pkg::range_t      out_range
);
   adc_port_pkg::code_t  code_reg  [`PIPE_DEPTH-1];
   adc_port_pkg::code_t  code_next [`PIPE_DEPTH-1];
   adc_port_pkg::range_t rng_reg   [`PIPE_DEPTH-1];
   adc_port_pkg::range_t rng_next  [`PIPE_DEPTH-1];

   // The capture and output registers around this pipe take two edges of
   // the five-edge latency between them, so it holds one stage fewer than the depth.
   genvar g;
   generate
      for (g = 0; g < `PIPE_DEPTH - 1; g = g + 1)
      begin : stage
         if (g == 0)
         begin : first
            always_comb
            begin
               code_next[g] = in_code;
               rng_next[g]  = in_range;
            end
         end
         else
         begin : rest
            always_comb
            begin
               code_next[g] = code_reg[g-1];
               rng_next[g]  = rng_reg[g-1];
            end
         end
         always_ff @(posedge clk)
         begin
            if (rst)
            begin
               code_reg[g] <= `CODE_MIN;
               rng_reg[g]  <= adc_port_pkg::RANGE_OK;
            end
            else
            begin
               code_reg[g] <= code_next[g];
               rng_reg[g]  <= rng_next[g];
            end
         end
      end
   endgenerate

   assign out_code  = code_reg[`PIPE_DEPTH-2];
   assign out_range = rng_reg[`PIPE_DEPTH-2];
endmodule

// [adc_port_monitor.sv]
// Concurrent checks on the converter port pins and Wishbone handshake.
// Assumes one clock domain and the synchronous active-high reset.
`timescale 1ns/10ps
module adc_port_monitor
(
   // Clock and reset
   input  wire logic       REF_CLK,
   input  wire logic       SYS_RST,
   // Sample path
   input  wire logic       SAMPLE_UNDER,
   input  wire logic       SAMPLE_OVER,
   input  wire logic [9:0] RESULT_BUS_IN,
   input  wire logic [9:0] RESULT_BUS_OUT,
   input  wire logic       RESULT_BUS_OE,
   input  wire logic       RANGE_EXCEEDED_FLAG,
   input  wire logic       RANGE_FLAG_OE,
   input  wire logic       OUTPUT_ENABLE_N,
   input  wire logic       WRITE_STROBE,
   // Control outputs
   input  wire logic       SLEEP_OUT,
   input  wire logic       CLAMP_ENABLE,
   input  wire logic [2:0] GAIN_CODE,
   // Wishbone
   input  wire logic       CYC_I,
   input  wire logic       STB_I,
   input  wire logic       ACK_O
);
   logic [2:0] quiet_reg;
   logic [2:0] quiet_next;
   // Counts cycles awake since reset or sleep so the pipeline holds real samples.
   always_comb
      quiet_next = (SYS_RST || SLEEP_OUT) ? 3'h0 :
                   ((quiet_reg == 3'h7) ? quiet_reg : quiet_reg + 3'h1);
   always_ff @(posedge REF_CLK)
      quiet_reg <= quiet_next;
   default clocking cb @(posedge REF_CLK); endclocking
   default disable iff (SYS_RST);
   AST_BUS_OE: assert property (
      RESULT_BUS_OE == !OUTPUT_ENABLE_N) else $error("bus enable wrong");
   AST_FLAG_OE: assert property (
      RANGE_FLAG_OE == !OUTPUT_ENABLE_N) else $error("flag enable wrong");
   AST_FLAG: assert property (
      (quiet_reg == 3'h7 && $past(SAMPLE_UNDER || SAMPLE_OVER, 5))
      |-> RANGE_EXCEEDED_FLAG) else $error("range flag missing");
   AST_SAT_OVER: assert property (
      (quiet_reg == 3'h7 && $past(SAMPLE_OVER, 5))
      |-> RESULT_BUS_OUT inside {10'h3ff, 10'h1ff}) else $error("no top code");
   AST_SAT_UNDER: assert property (
      (quiet_reg == 3'h7 && $past(SAMPLE_UNDER, 5))
      |-> RESULT_BUS_OUT inside {10'h000, 10'h200}) else $error("no low code");
   AST_PIN_CTRL: assert property (
      ($fell(WRITE_STROBE) && OUTPUT_ENABLE_N && !CYC_I
       && $past(RESULT_BUS_IN[9:8]) == 2'h0)
      |=> SLEEP_OUT == $past(RESULT_BUS_IN[3], 2)
          && CLAMP_ENABLE == !$past(RESULT_BUS_IN[6], 2))
      else $error("pin control write lost");
   AST_PIN_GAIN: assert property (
      ($fell(WRITE_STROBE) && OUTPUT_ENABLE_N && !CYC_I
       && $past(RESULT_BUS_IN[9:8]) == 2'h2)
      |=> GAIN_CODE == $past(RESULT_BUS_IN[2:0], 2))
      else $error("pin gain write lost");
   AST_REFUSED: assert property (
      ($fell(WRITE_STROBE) && !OUTPUT_ENABLE_N && !CYC_I)
      |=> $stable(GAIN_CODE) && $stable(SLEEP_OUT))
      else $error("write taken while outputs on");
   AST_ACK: assert property (
      (CYC_I && STB_I && !ACK_O) |=> ACK_O ##1 !ACK_O)
      else $error("ack not one cycle after request");
endmodule
bind adc_digital_port adc_port_monitor mon
(
   .REF_CLK(REF_CLK), .SYS_RST(SYS_RST), .SAMPLE_UNDER(SAMPLE_UNDER),
   .SAMPLE_OVER(SAMPLE_OVER), .RESULT_BUS_IN(RESULT_BUS_IN),
   .RESULT_BUS_OUT(RESULT_BUS_OUT), .RESULT_BUS_OE(RESULT_BUS_OE),
   .RANGE_EXCEEDED_FLAG(RANGE_EXCEEDED_FLAG), .RANGE_FLAG_OE(RANGE_FLAG_OE),
   .OUTPUT_ENABLE_N(OUTPUT_ENABLE_N), .WRITE_STROBE(WRITE_STROBE),
   .SLEEP_OUT(SLEEP_OUT), .CLAMP_ENABLE(CLAMP_ENABLE), .GAIN_CODE(GAIN_CODE),
   .CYC_I(CYC_I), .STB_I(STB_I), .ACK_O(ACK_O)
);

// [adc_port_params.svh]
// Constants for the converter digital port: control bit positions,
// reset values, register indices and the pipeline depth.
// Assumes inclusion by bare name from the design files.
`ifndef ADC_PORT_PARAMS_SVH
`define ADC_PORT_PARAMS_SVH

`define DATA_W            10
`define PIPE_DEPTH        4
`define CODE_MIN          10'h000
`define CODE_MAX          10'h3ff
`define MSB_FLIP          10'h200

// Configuration word layout on the shared pins.
`define ADDR_LSB          8
`define ADDR_W            2
`define IDX_CONTROL       2'h0
`define IDX_CLAMP         2'h1
`define IDX_GAIN          2'h2
`define SLEEP_BIT         3
`define SIGNED_BIT        5
`define CLAMP_OFF_BIT     6
`define CLAMP_SRC_BIT     7
`define GAIN_W            3

// Reset values of the control state.
`define CONTROL_RST       8'h00
`define CLAMP_RST         10'h000
`define GAIN_RST          3'h0

// Wishbone register offsets (byte addresses).
`define WB_SAMPLE         4'h0
`define WB_CONTROL        4'h4
`define WB_CLAMP          4'h8
`define WB_GAIN           4'hc

`endif

// [adc_port_pkg.sv]
// Types shared by the converter digital port.
// Assumes adc_port_params.svh for the widths.
`include "adc_port_params.svh"
package adc_port_pkg;
   typedef logic [`DATA_W-1:0] code_t;
   typedef enum logic [1:0]
   {
      RANGE_OK    = 2'b00,
      RANGE_UNDER = 2'b01,
      RANGE_OVER  = 2'b10
   } range_t;
endpackage

// [test_adc_digital_port.sv]
// Self-checking bench: sample path, pin writes and Wishbone registers.
// Assumes the host model on the shared pins and the bound monitor.
`timescale 1ns/10ps
module test_adc_digital_port;
   logic clk = 1'b0, rst = 1'b1, und = 1'b0, range_exceeded_flag = 1'b0;
   logic [10:0] val = 11'h000;
   logic cyc = 1'b0, stb = 1'b0, we = 1'b0;
   logic [3:0] adr = 4'h0, sel = 4'h0;
   logic [31:0] dat = 32'h0, rd;
   wire [31:0] dat_o;
   wire [9:0] bus_out, pins, clamp_code;
   wire [2:0] gain;
   wire bus_oe, flag, flag_oe, oe_n, strobe, sleep, clamp_en, clamp_src, ack;
   int err_count = 0, checks_done = 0, cycles = 0;
   localparam logic [12:0] TBL [8] = '{13'h0000, 13'h01ff, 13'h0600,
      13'h1000, 13'h0800, 13'h0258, 13'h07ff, 13'h0064};
   adc_digital_port dut(.REF_CLK(clk), .SYS_RST(rst), .SAMPLE_VALUE(val),
      .SAMPLE_UNDER(und), .SAMPLE_OVER(range_exceeded_flag), .RESULT_BUS_IN(pins),
      .RESULT_BUS_OUT(bus_out), .RESULT_BUS_OE(bus_oe),
      .RANGE_EXCEEDED_FLAG(flag), .RANGE_FLAG_OE(flag_oe),
      .OUTPUT_ENABLE_N(oe_n), .WRITE_STROBE(strobe), .SLEEP_OUT(sleep),
      .CLAMP_ENABLE(clamp_en), .CLAMP_FROM_DAC(clamp_src),
      .CLAMP_DAC_CODE(clamp_code), .GAIN_CODE(gain), .CYC_I(cyc),
      .STB_I(stb), .WE_I(we), .ADR_I(adr), .SEL_I(sel), .DAT_I(dat),
      .DAT_O(dat_o), .ACK_O(ack));
   adc_host_model host(.clk(clk), .dev_out(bus_out), .dev_oe(bus_oe),
      .pins(pins), .oe_n(oe_n), .strobe(strobe));
   initial
      forever #20 clk = ~clk;
   task automatic close_out();
      $display("checks %0d mismatches %0d", checks_done, err_count);
      if (err_count == 0 && checks_done > 0)
         $display("[ PASS ]");
      else
         $display("[ FAIL ]");
      $finish;
   endtask
   always @(posedge clk)
   begin
      cycles++;
      if (cycles > 20000)
      begin
         err_count++;
         close_out();
      end
   end
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      checks_done++;
      if (seen !== exp)
      begin
         err_count++;
         $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask
   task automatic wb(input logic w, input logic [3:0] a,
                     input logic [31:0] d, output logic [31:0] q);
      @(posedge clk);
      cyc <= 1'b1; stb <= 1'b1; we <= w; adr <= a; sel <= 4'hf; dat <= d;
      do @(posedge clk); while (ack !== 1'b1);
      q = dat_o;
      cyc <= 1'b0; stb <= 1'b0; we <= 1'b0;
   endtask
   // Expected flag and code: saturate, offset, optional msb flip.
   function automatic logic [10:0] expect_of(input logic [12:0] t,
                                             input logic s);
      logic f;
      logic [9:0] c;
      f = t[12] | t[11] | ($signed(t[10:0]) < -512) | ($signed(t[10:0]) > 511);
      if (t[12] || $signed(t[10:0]) < -512) c = 10'h000;
      else if (f) c = 10'h3ff;
      else c = t[9:0] + 10'h200;
      return {f, s ? c ^ 10'h200 : c};
   endfunction
   task automatic run_samples(input logic s, input logic slept);
      for (int i = 0; i < 13; i++)
      begin
         @(posedge clk);
         {und, range_exceeded_flag, val} <= (i < 8) ? TBL[i] : 13'h0000;
         #1;
         if (i >= 5)
            check(32'({flag, bus_out}), 32'(slept ? 11'h0 : expect_of(TBL[i-5], s)));
      end
   endtask
   initial
   begin
      repeat (10) @(posedge clk);
      rst <= 1'b0;
      wb(1'b0, 4'h4, 32'h0, rd); check(rd, 32'h0);
      wb(1'b0, 4'hc, 32'h0, rd); check(rd, 32'h0);
      run_samples(1'b0, 1'b0);
      host.pin_write(10'h020, 1'b1);
      run_samples(1'b1, 1'b0);
      wb(1'b1, 4'h4, 32'h08, rd); check(32'(sleep), 32'h1);
      repeat (6) @(posedge clk);
      run_samples(1'b0, 1'b1);
      host.pin_write(10'h040, 1'b1); check(32'({sleep, clamp_en}), 32'h0);
      host.pin_write(10'h080, 1'b1); check(32'({clamp_en, clamp_src}), 32'h3);
      host.pin_write(10'h155, 1'b1); check(32'(clamp_code), 32'h55);
      wb(1'b1, 4'h8, 32'h3ab, rd);
      wb(1'b0, 4'h8, 32'h0, rd); check(rd, 32'h3ab);
      host.pin_write(10'h205, 1'b1); check(32'(gain), 32'h5);
      host.pin_write(10'h202, 1'b0); check(32'(gain), 32'h5);
      wb(1'b0, 4'hc, 32'h0, rd); check(rd, 32'h5);
      wb(1'b0, 4'h2, 32'h0, rd); check(rd, 32'h0);
      wb(1'b0, 4'h0, 32'h0, rd); check(rd, 32'h200);
      close_out();
   end
endmodule
